// ===== rtl/tpi_timer_block.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpi_defines.svh"
module tpi_timer_block (
  input wire logic mclk,
  input wire logic rst,
  input wire tpi_pkg::tpi_main_cfg_t main_cfg,
  input wire tpi_pkg::tpi_ch16_cfg_t [`TPI_MAIN_CH-1:0] ch_cfg,
  input wire tpi_pkg::tpi_small_cfg_t [`TPI_SMALL_INST-1:0] small_cfg,
  input wire logic main_event,
  input wire logic [`TPI_SMALL_INST-1:0] small_event,
  input wire logic [`TPI_MAIN_CH-1:0] ch_in,
  output logic [15:0] main_count,
  output logic [`TPI_MAIN_CH-1:0] ch_pwm,
  output logic [`TPI_MAIN_CH-1:0] ch_cap_valid,
  output logic [`TPI_MAIN_CH*16-1:0] ch_cap_value,
  output logic ir_out,
  output logic [`TPI_SMALL_INST*8-1:0] small_count,
  output logic [`TPI_SMALL_INST-1:0] small_pwm
);
  // Main timer state
  logic [7:0] pre16_r;
  logic [7:0] pre16_nxt;
  logic [15:0] cnt16_r;
  logic [15:0] cnt16_nxt;
  logic tick16; // Count enable for main timer
  logic wrap16; // Main timer at period this tick
  logic [`TPI_SMALL_INST-1:0] wrap8; // Small timer period completes
  logic [7:0] cnt8 [`TPI_SMALL_INST]; // Small timer counts
  logic ir_nxt;
  logic [`TPI_MAIN_CH-1:0] in_d_r; // Previous channel inputs
  logic [`TPI_MAIN_CH-1:0] pwm_r;
  logic [`TPI_MAIN_CH-1:0] pwm_nxt;

  // Small timers, one per instance
  genvar gi;
  generate
    for (gi = 0; gi < `TPI_SMALL_INST; gi++)
    begin : g_small
      logic [7:0] pre_r;
      logic [7:0] pre_nxt;
      logic [7:0] cnt_r;
      logic [7:0] cnt_nxt;
      logic pwm_r8;
      logic pwm_n8;
      logic tick;
      // Tick, wrap and PWM next values
      always_comb
      begin
        pre_nxt = pre_r;
        tick = 1'b0;
        case (small_cfg[gi].mode)
          tpi_pkg::TPI_MODE_FREE:
          begin
            // Prescaler divides by prescale+1
            if (pre_r >= small_cfg[gi].prescale)
            begin
              pre_nxt = `TPI_PRE_RST;
              tick = 1'b1;
            end
            else
            begin
              pre_nxt = pre_r + 8'h01;
            end
          end
          tpi_pkg::TPI_MODE_EVENT: tick = small_event[gi]; // Counter use
          default: pre_nxt = `TPI_PRE_RST;
        endcase
        wrap8[gi] = tick && (cnt_r >= small_cfg[gi].period);
        cnt_nxt = cnt_r;
        pwm_n8 = pwm_r8;
        if (tick)
        begin
          // Restart from zero past period
          cnt_nxt = wrap8[gi] ? `TPI_CNT8_RST : cnt_r + 8'h01;
          // Match clears, wrap sets: duty from compare
          if (wrap8[gi])
            pwm_n8 = 1'b1;
          else if (cnt_r + 8'h01 == small_cfg[gi].cmp)
            pwm_n8 = 1'b0;
        end
      end
      // Small timer registers
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          pre_r <= `TPI_PRE_RST;
          cnt_r <= `TPI_CNT8_RST;
          pwm_r8 <= 1'b1;
          small_pwm[gi] <= 1'b1;
          small_count[gi*8 +: 8] <= `TPI_CNT8_RST;
        end
        else
        begin
          pre_r <= pre_nxt;
          cnt_r <= cnt_nxt;
          pwm_r8 <= pwm_n8;
          small_pwm[gi] <= pwm_n8;
          small_count[gi*8 +: 8] <= cnt_nxt;
        end
      end
      assign cnt8[gi] = cnt_r;
      // Count must be zero exactly one cycle after a wrap
      a_small_wrap: assert property (@(posedge mclk) disable iff (rst)
        wrap8[gi] |=> (cnt_r == 8'h00))
        else $error("small timer did not restart at zero");
    end
  endgenerate

  // Main timer prescale, tick source and count
  always_comb
  begin
    pre16_nxt = pre16_r;
    tick16 = 1'b0;
    if (main_cfg.ir_en)
    begin
      tick16 = wrap8[0]; // Count carrier periods
      pre16_nxt = `TPI_PRE_RST;
    end
    else
    begin
      case (main_cfg.mode)
        tpi_pkg::TPI_MODE_FREE:
        begin
          // Programmable prescaler
          if (pre16_r >= main_cfg.prescale)
          begin
            pre16_nxt = `TPI_PRE_RST;
            tick16 = 1'b1;
          end
          else
          begin
            pre16_nxt = pre16_r + 8'h01;
          end
        end
        tpi_pkg::TPI_MODE_EVENT: tick16 = main_event; // Event counting
        default: pre16_nxt = `TPI_PRE_RST;
      endcase
    end
    wrap16 = tick16 && (cnt16_r >= main_cfg.period); // Period sets range
    cnt16_nxt = cnt16_r;
    if (tick16)
      cnt16_nxt = wrap16 ? `TPI_CNT16_RST : cnt16_r + 16'h0001; // 16-bit count
  end

  // Main channel PWM next values
  always_comb
  begin
    pwm_nxt = pwm_r;
    for (int i = 0; i < `TPI_MAIN_CH; i++)
    begin
      if (tick16 && !ch_cfg[i].capture)
      begin
        // Compare against running count
        if (wrap16)
          pwm_nxt[i] = 1'b1;
        else if (cnt16_r + 16'h0001 == ch_cfg[i].cmp)
          pwm_nxt[i] = 1'b0;
      end
    end
    // Gate channel 0 with the carrier
    ir_nxt = main_cfg.ir_en ? (pwm_nxt[0] & g_small[0].pwm_n8) : pwm_nxt[0];
  end

  // Main timer registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre16_r <= `TPI_PRE_RST;
      cnt16_r <= `TPI_CNT16_RST;
      main_count <= `TPI_CNT16_RST;
      pwm_r <= '1;
      ch_pwm <= '1;
      ir_out <= 1'b1;
    end
    else
    begin
      pre16_r <= pre16_nxt;
      cnt16_r <= cnt16_nxt;
      main_count <= cnt16_nxt;
      pwm_r <= pwm_nxt;
      ch_pwm <= pwm_nxt;
      ir_out <= ir_nxt;
    end
  end

  // Edge capture per channel
  generate
    for (gi = 0; gi < `TPI_MAIN_CH; gi++)
    begin : g_cap
      logic edge_hit;
      logic [15:0] cap_nxt;
      always_comb
      begin
        edge_hit = ch_cfg[gi].capture && (ch_in[gi] != in_d_r[gi]);
        cap_nxt = edge_hit ? cnt16_r : ch_cap_value[gi*16 +: 16]; // Capture on edge
      end
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          in_d_r[gi] <= 1'b0;
          ch_cap_valid[gi] <= 1'b0;
          ch_cap_value[gi*16 +: 16] <= `TPI_CNT16_RST;
        end
        else
        begin
          in_d_r[gi] <= ch_in[gi];
          ch_cap_valid[gi] <= edge_hit;
          ch_cap_value[gi*16 +: 16] <= cap_nxt;
        end
      end
      a_cap_value: assert property (@(posedge mclk) disable iff (rst)
        edge_hit |=> (ch_cap_valid[gi] && ch_cap_value[gi*16 +: 16] == $past(cnt16_r)))
        else $error("capture did not record the count");
    end
  endgenerate

  // Carrier-gated pin follows both sources
  a_ir_gate: assert property (@(posedge mclk) disable iff (rst)
    main_cfg.ir_en |=> (ir_out == (ch_pwm[0] & small_pwm[0])))
    else $error("ir output not gated by carrier");
  // In IR mode count moves only on carrier wrap
  a_ir_tick: assert property (@(posedge mclk) disable iff (rst)
    (main_cfg.ir_en && !wrap8[0]) |=> $stable(main_count))
    else $error("main timer moved without carrier period");
  // Count restarts at zero the cycle after a wrap
  a_main_wrap: assert property (@(posedge mclk) disable iff (rst)
    wrap16 |=> (main_count == 16'h0000))
    else $error("main timer did not restart");
  // Stop mode holds the count
  a_main_stop: assert property (@(posedge mclk) disable iff (rst)
    (!main_cfg.ir_en && main_cfg.mode == tpi_pkg::TPI_MODE_STOP) |=> $stable(main_count))
    else $error("main timer moved while stopped");
  // Event mode advances by one on an event
  a_main_event: assert property (@(posedge mclk) disable iff (rst)
    (!main_cfg.ir_en && main_cfg.mode == tpi_pkg::TPI_MODE_EVENT && main_event && !wrap16)
      |=> (main_count == $past(main_count) + 16'h0001))
    else $error("event did not advance count");
  // Channel goes low on compare match
  a_ch_match: assert property (@(posedge mclk) disable iff (rst)
    (tick16 && !wrap16 && !ch_cfg[1].capture && cnt16_r + 16'h0001 == ch_cfg[1].cmp)
      |=> !ch_pwm[1])
    else $error("channel missed compare match");
  // Small channel low on match
  a_small_match: assert property (@(posedge mclk) disable iff (rst)
    (g_small[1].tick && !wrap8[1] && cnt8[1] + 8'h01 == small_cfg[1].cmp) |=> !small_pwm[1])
    else $error("small channel missed compare match");
endmodule
`default_nettype wire

// ===== rtl/tpi_defines.svh
`ifndef TPI_DEFINES_SVH
`define TPI_DEFINES_SVH
// Reset values of counters and prescalers
`define TPI_CNT16_RST 16'h0000
`define TPI_CNT8_RST 8'h00
`define TPI_PRE_RST 8'h00
// Channel counts
`define TPI_MAIN_CH 5
`define TPI_SMALL_INST 2
`endif

// ===== rtl/tpi_pkg.sv
`default_nettype none
package tpi_pkg;
  // Operating modes of a timer
  typedef enum logic [2:0] {
    TPI_MODE_STOP = 3'h1,
    TPI_MODE_FREE = 3'h2,
    TPI_MODE_EVENT = 3'h4
  } tpi_mode_t;
  // Main timer configuration
  typedef struct packed {
    tpi_mode_t mode;
    logic ir_en;
    logic [7:0] prescale;
    logic [15:0] period;
  } tpi_main_cfg_t;
  // Main timer channel configuration
  typedef struct packed {
    logic capture;
    logic [15:0] cmp;
  } tpi_ch16_cfg_t;
  // Small timer configuration
  typedef struct packed {
    tpi_mode_t mode;
    logic [7:0] prescale;
    logic [7:0] period;
    logic [7:0] cmp;
  } tpi_small_cfg_t;
endpackage
`default_nettype wire

// ===== tb/tpi_timer_block_bench.sv
`timescale 1ns/100ps
`default_nettype none
module tpi_timer_block_bench;
  // Stimulus and observed outputs
  logic mclk = 1'b0;
  logic rst = 1'b1;
  tpi_pkg::tpi_main_cfg_t main_cfg;
  tpi_pkg::tpi_ch16_cfg_t [4:0] ch_cfg;
  tpi_pkg::tpi_small_cfg_t [1:0] small_cfg;
  logic main_event = 1'b0;
  logic [1:0] small_event = 2'h0;
  logic [4:0] ch_in = 5'h00;
  logic [15:0] main_count;
  logic [4:0] ch_pwm;
  logic [4:0] ch_cap_valid;
  logic [79:0] ch_cap_value;
  logic ir_out;
  logic [15:0] small_count;
  logic [1:0] small_pwm;
  int fail_count = 0;
  int num_checks = 0;
  // Clock of 100 ns
  always #50 mclk = ~mclk;
  tpi_timer_block uut (.mclk(mclk), .rst(rst), .main_cfg(main_cfg), .ch_cfg(ch_cfg),
    .small_cfg(small_cfg), .main_event(main_event), .small_event(small_event),
    .ch_in(ch_in), .main_count(main_count), .ch_pwm(ch_pwm), .ch_cap_valid(ch_cap_valid),
    .ch_cap_value(ch_cap_value), .ir_out(ir_out), .small_count(small_count),
    .small_pwm(small_pwm));
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  // Advance n edges, land just after the last one
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Free run, wrap at period, PWM level against compare
  task automatic t_free();
    logic [15:0] c;
    logic p;
    logic p1;
    main_cfg = '{mode: tpi_pkg::TPI_MODE_FREE, ir_en: 1'b0, prescale: 8'h00, period: 16'h0003};
    ch_cfg[0] = '{capture: 1'b0, cmp: 16'h0002};
    ch_cfg[1] = '{capture: 1'b0, cmp: 16'h0001};
    step(1);
    repeat (12)
    begin
      c = main_count;
      p = ch_pwm[0];
      p1 = ch_pwm[1];
      step(1);
      chk(main_count, (c >= 16'h0003) ? 16'h0000 : c + 16'h0001, "wrap");
      chk({15'h0, ch_pwm[0]}, {15'h0, (main_count == 16'h0) | (p & (main_count != 16'h2))},
        "pwm");
      chk({15'h0, ir_out}, {15'h0, ch_pwm[0]}, "plain out");
      chk({15'h0, ch_pwm[1]}, {15'h0, (main_count == 16'h0) | (p1 & (main_count != 16'h1))},
        "pwm ch1");
    end
  endtask
  // Prescaler of 2 gives one tick every third cycle
  task automatic t_prescale();
    logic [15:0] c;
    main_cfg.prescale = 8'h02;
    main_cfg.period = 16'hFFFF;
    c = main_count;
    for (int i = 0; i < 8 && main_count === c; i++) step(1);
    repeat (3)
    begin
      c = main_count;
      step(2);
      chk(main_count, c, "pre hold");
      step(1);
      chk(main_count, c + 16'h0001, "pre tick");
    end
  endtask
  // Back-to-back events, then both edges captured on a still count
  task automatic t_event_capture();
    logic [15:0] c;
    logic [7:0] s;
    // Stop mode must hold the count
    main_cfg.mode = tpi_pkg::TPI_MODE_STOP;
    c = main_count;
    step(3);
    chk(main_count, c, "stop hold");
    main_cfg.mode = tpi_pkg::TPI_MODE_EVENT;
    small_cfg[1].mode = tpi_pkg::TPI_MODE_EVENT;
    small_cfg[1].cmp = 8'h02;
    ch_cfg[1] = '{capture: 1'b1, cmp: 16'h0000};
    step(2);
    c = main_count;
    s = small_count[15:8];
    main_event = 1'b1;
    small_event = 2'h2;
    step(4);
    main_event = 1'b0;
    small_event = 2'h0;
    step(1);
    chk(main_count, c + 16'h0004, "events");
    chk({8'h0, small_count[15:8]}, {8'h0, s + 8'h04}, "small events");
    chk({15'h0, small_pwm[1]}, 16'h0000, "small match");
    repeat (2)
    begin
      ch_in[1] = ~ch_in[1];
      for (int i = 0; i < 4 && ch_cap_valid[1] !== 1'b1; i++) step(1);
      chk({15'h0, ch_cap_valid[1]}, 16'h0001, "cap seen");
      chk(ch_cap_value[31:16], c + 16'h0004, "cap value");
      step(1);
      chk({15'h0, ch_cap_valid[1]}, 16'h0000, "cap pulse");
    end
  endtask
  // Small timer duty: period 4, compare 2 gives 2 high of 5
  task automatic t_small_pwm();
    int hi;
    small_cfg[0] = '{mode: tpi_pkg::TPI_MODE_FREE, prescale: 8'h00, period: 8'h04, cmp: 8'h02};
    hi = 0;
    step(1);
    for (int i = 0; i < 8 && small_count[7:0] !== 8'h00; i++) step(1);
    repeat (5)
    begin
      hi += int'(small_pwm[0]);
      step(1);
    end
    chk(16'(hi), 16'h0002, "duty");
    chk({8'h0, small_count[7:0]}, 16'h0000, "small wrap");
  endtask
  // Carrier mode: main counts small wraps, output is the AND
  task automatic t_ir();
    logic [15:0] c;
    main_cfg = '{mode: tpi_pkg::TPI_MODE_FREE, ir_en: 1'b1, prescale: 8'h00, period: 16'h0003};
    repeat (40)
    begin
      c = main_count;
      step(1);
      chk(main_count, (small_count[7:0] != 8'h0) ? c : (c >= 16'h3) ? 16'h0 : c + 16'h1,
        "ir count");
      chk({15'h0, ir_out}, {15'h0, ch_pwm[0] & small_pwm[0]}, "ir and");
    end
  endtask
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge mclk);
    fail_count++;
    give_verdict();
  end
  // Main sequence
  initial
  begin
    main_cfg = '{mode: tpi_pkg::TPI_MODE_STOP, ir_en: 1'b0, prescale: 8'h00, period: 16'hFFFF};
    ch_cfg = '0;
    small_cfg[0] = '{mode: tpi_pkg::TPI_MODE_STOP, prescale: 8'h00, period: 8'hFF, cmp: 8'h00};
    small_cfg[1] = small_cfg[0];
    step(20);
    rst = 1'b0;
    t_free();
    t_prescale();
    t_event_capture();
    t_small_pwm();
    t_ir();
    give_verdict();
  end
endmodule
`default_nettype wire
